// >>> pcrs_defs.svh
// constants of the program counter and return stack block
`ifndef PCRS_DEFS_SVH
`define PCRS_DEFS_SVH
`define PCRS_PC_W 21
`define PCRS_SP_W 5
`define PCRS_DEPTH 31
`define PCRS_SP_TOP 5'h1F
`define PCRS_SP_LAST 5'h1E
`define PCRS_STEP 21'h000002
`define PCRS_AW 6
`define PCRS_A_CLB 6'h00
`define PCRS_A_HIL 6'h04
`define PCRS_A_UPL 6'h08
`define PCRS_A_SP 6'h0C
`define PCRS_A_TOP_LO 6'h10
`define PCRS_A_TOP_HI 6'h14
`define PCRS_A_TOP_UP 6'h18
`define PCRS_A_CFG 6'h1C
`define PCRS_A_PC 6'h20
`define PCRS_FULL_BIT 7
`define PCRS_UNF_BIT 6
`define PCRS_ORE_RST 1'b1
`define PCRS_RESP_OK 2'h0
`define PCRS_RESP_ERR 2'h2
`endif

// >>> pcrs_pkg.sv
// types shared by the program counter and return stack block
package pcrs_pkg;
  typedef enum logic [2:0] {
    PCRS_OP_NONE = 3'b000,
    PCRS_OP_ADV = 3'b001,
    PCRS_OP_JUMP = 3'b010,
    PCRS_OP_CALL = 3'b011,
    PCRS_OP_RET = 3'b100,
    PCRS_OP_IRQ = 3'b101,
    PCRS_OP_PUSH = 3'b110,
    PCRS_OP_POP = 3'b111
  } pcrs_op_t;
endpackage

// >>> pcrs_top.sv
// program counter and hardware return stack with an AXI4-Lite register slave
//
// Functional notes
// - program counter is 21 bits, byte addressed, in low, high, upper bytes
// - low byte is software read/write; high byte only loads through high latch
// - upper bits 20:16 read back in the full counter word at 0x20 or through the upper latch after a low byte read, and load only through the upper latch
// - a low byte write loads high and upper bytes from the latches unless a device reset or a sequencer load, return or advance takes the counter that cycle
// - a low byte read copies high and upper bytes into the latches unless a device reset clears them that cycle
// - counter bit 0 is always zero
// - sequential fetch advances the counter by two
// - call, jump and interrupt acknowledge load the target directly, latches not used
// - stack is 31 entries of 21 bits with a 5-bit pointer
// - call and interrupt acknowledge push; the return pops into the counter
// - call and return leave both latches unchanged unless they trigger the overflow or underflow reset
// - push increments the pointer first, then writes the addressed entry
// - pop loads the counter from the addressed entry, then decrements
// - every reset zeroes the pointer; pointer zero has no entry
// - only the top entry is visible, through three byte registers
// - pointer ranges 0 to 31 and is software read/write
// - the 31st push sets the full flag; software or power-on clears it
// - with overflow reset on, 31st push stores, flags, resets, pointer zero
// - with overflow reset off, pointer stays 31 and later pushes are dropped
// - pop on empty stack loads zero, sets underflow, pointer stays zero
// - with overflow reset off, underflow only redirects to zero, no other state is reset
// - overflow reset on also resets on underflow; off only sets flags
// - software pop discards top entry; software push stores the counter
`timescale 1ns/100ps
`include "pcrs_defs.svh"
`default_nettype none
module pcrs_top (
  input wire logic clk, // core clock, 100 MHz
  input wire logic rst, // power-on reset, async, active high
  input wire logic sys_reset, // other device resets, sync, active high
  input wire pcrs_pkg::pcrs_op_t seq_op, // sequencer operation this cycle
  input wire logic [`PCRS_PC_W-1:0] seq_target, // jump, call or vector target
  output logic [`PCRS_PC_W-1:0] instruction_pointer, // current counter
  output logic stack_full_flag, // sticky full flag
  output logic stack_underflow_flag, // sticky underflow flag
  output logic stack_reset_req, // one-cycle device reset request
  input wire logic [`PCRS_AW-1:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write byte enables
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [`PCRS_AW-1:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready // read data ready
);
  logic [`PCRS_PC_W-1:0] pc_r, pc_nxt;
  logic [`PCRS_SP_W-1:0] sp_r, sp_nxt;
  logic [7:0] hil_r, hil_nxt;
  logic [4:0] upl_r, upl_nxt;
  logic full_r, unf_r, ore_r, req_r;
  // return stack storage; pointer zero has no entry
  logic [`PCRS_PC_W-1:0] stk_mem [1:`PCRS_DEPTH];
  logic aw_v_r, w_v_r, bvalid_r, rvalid_r;
  logic [`PCRS_AW-1:0] awaddr_r;
  logic [7:0] wdata_r;
  logic wstb_r;
  logic [1:0] bresp_r, rresp_r;
  logic [31:0] rdata_r;

  // bus handshakes
  wire wr_fire = aw_v_r & w_v_r & ~bvalid_r;
  wire rd_fire = s_axi_arvalid & ~rvalid_r;
  wire sw_we = wr_fire & wstb_r;
  wire we_clb = sw_we & (awaddr_r == `PCRS_A_CLB);
  wire we_hil = sw_we & (awaddr_r == `PCRS_A_HIL);
  wire we_upl = sw_we & (awaddr_r == `PCRS_A_UPL);
  wire we_sp = sw_we & (awaddr_r == `PCRS_A_SP);
  wire we_top_lo = sw_we & (awaddr_r == `PCRS_A_TOP_LO);
  wire we_top_hi = sw_we & (awaddr_r == `PCRS_A_TOP_HI);
  wire we_top_up = sw_we & (awaddr_r == `PCRS_A_TOP_UP);
  wire we_cfg = sw_we & (awaddr_r == `PCRS_A_CFG);
  wire rd_clb = rd_fire & (s_axi_araddr == `PCRS_A_CLB);

  // address decode for the answer code
  wire wr_hit = (awaddr_r <= `PCRS_A_PC) & (awaddr_r[1:0] == 2'h0);
  wire rd_hit = (s_axi_araddr <= `PCRS_A_PC) & (s_axi_araddr[1:0] == 2'h0);

  // sequencer decode
  // push and pop sources
  wire is_push = (seq_op == pcrs_pkg::PCRS_OP_CALL) | (seq_op == pcrs_pkg::PCRS_OP_IRQ) |
                 (seq_op == pcrs_pkg::PCRS_OP_PUSH);
  wire is_ret = (seq_op == pcrs_pkg::PCRS_OP_RET);
  wire is_pop = is_ret | (seq_op == pcrs_pkg::PCRS_OP_POP);
  wire is_load = (seq_op == pcrs_pkg::PCRS_OP_JUMP) | (seq_op == pcrs_pkg::PCRS_OP_CALL) |
                 (seq_op == pcrs_pkg::PCRS_OP_IRQ);
  wire sp_zero = (sp_r == 5'h00);
  wire sp_top = (sp_r == `PCRS_SP_TOP);

  // top entry view
  // only the addressed entry is visible
  wire [`PCRS_PC_W-1:0] stack_top = sp_zero ? 21'h000000 : stk_mem[sp_r];

  // overflow and underflow events
  // full on reaching or sitting at the last entry
  wire full_evt = is_push & (sp_r >= `PCRS_SP_LAST);
  wire unf_evt = is_pop & sp_zero;
  // reset on either event only while enabled
  wire ovf_rst = full_evt & ore_r;
  wire unf_rst = unf_evt & ore_r;
  wire dev_clr = sys_reset | ovf_rst | unf_rst;

  // write target is the incremented pointer
  wire [`PCRS_SP_W-1:0] sp_inc = sp_r + 5'h01;
  // no write beyond the last entry
  wire push_wr = is_push & ~sp_top;
  // latched upper bits joined to the written low byte
  wire [`PCRS_PC_W-1:0] pc_sw = {upl_r, hil_r, wdata_r[7:1], 1'b0};
  // return value taken before the pointer moves
  // empty stack returns zero; other state resets only with overflow reset on
  wire [`PCRS_PC_W-1:0] pc_ret = stack_top;

  // next counter value
  always_comb begin
    pc_nxt = pc_r;
    if (dev_clr) begin
      pc_nxt = 21'h000000;
    end else if (is_ret) begin
      pc_nxt = pc_ret;
    end else if (is_load) begin
      pc_nxt = seq_target;
    end else if (seq_op == pcrs_pkg::PCRS_OP_ADV) begin
      pc_nxt = pc_r + `PCRS_STEP;
    end else if (we_clb) begin
      pc_nxt = pc_sw;
    end
    pc_nxt[0] = 1'b0;
  end

  // next pointer value
  always_comb begin
    sp_nxt = sp_r;
    if (dev_clr) begin
      sp_nxt = 5'h00;
    end else if (is_push) begin
      sp_nxt = sp_top ? sp_r : sp_inc;
    end else if (is_pop) begin
      sp_nxt = sp_zero ? sp_r : sp_r - 5'h01;
    end else if (we_sp) begin
      sp_nxt = wdata_r[`PCRS_SP_W-1:0];
    end
  end

  // next latch values
  // sequencer operations change the latches only through an overflow or underflow reset
  always_comb begin
    hil_nxt = hil_r;
    upl_nxt = upl_r;
    if (dev_clr) begin
      hil_nxt = 8'h00;
      upl_nxt = 5'h00;
    end else if (rd_clb) begin
      hil_nxt = pc_r[15:8];
      upl_nxt = pc_r[20:16];
    end else begin
      if (we_hil) begin
        hil_nxt = wdata_r;
      end
      if (we_upl) begin
        upl_nxt = wdata_r[4:0];
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pc_r <= 21'h000000;
      sp_r <= 5'h00;
      hil_r <= 8'h00;
      upl_r <= 5'h00;
    end else begin
      pc_r <= pc_nxt;
      sp_r <= sp_nxt;
      hil_r <= hil_nxt;
      upl_r <= upl_nxt;
    end
  end

  // stack entries: hardware push wins over a top register write
  always_ff @(posedge clk) begin
    if (push_wr) begin
      stk_mem[sp_inc] <= pc_r;
    end else if (!sp_zero && !is_pop) begin
      // byte writes into the top entry
      if (we_top_lo) begin
        stk_mem[sp_r][7:0] <= wdata_r;
      end
      if (we_top_hi) begin
        stk_mem[sp_r][15:8] <= wdata_r;
      end
      if (we_top_up) begin
        stk_mem[sp_r][20:16] <= wdata_r[4:0];
      end
    end
  end

  // sticky flags: set wins over a software clear, only software or power-on clears
  // flag set and clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      full_r <= 1'b0;
      unf_r <= 1'b0;
    end else begin
      full_r <= full_evt | (full_r & ~(we_sp & ~wdata_r[`PCRS_FULL_BIT]));
      unf_r <= unf_evt | (unf_r & ~(we_sp & ~wdata_r[`PCRS_UNF_BIT]));
    end
  end

  // overflow reset enable and device reset request
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ore_r <= `PCRS_ORE_RST;
      req_r <= 1'b0;
    end else begin
      ore_r <= we_cfg ? wdata_r[0] : ore_r;
      req_r <= ovf_rst | unf_rst;
    end
  end

  // write channel capture
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      aw_v_r <= 1'b0;
      w_v_r <= 1'b0;
      awaddr_r <= 6'h00;
      wdata_r <= 8'h00;
      wstb_r <= 1'b0;
    end else begin
      if (s_axi_awvalid && !aw_v_r) begin
        aw_v_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_v_r <= 1'b0;
      end
      if (s_axi_wvalid && !w_v_r) begin
        w_v_r <= 1'b1;
        wdata_r <= s_axi_wdata[7:0];
        wstb_r <= s_axi_wstrb[0];
      end else if (wr_fire) begin
        w_v_r <= 1'b0;
      end
    end
  end

  // write response
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bvalid_r <= 1'b0;
      bresp_r <= `PCRS_RESP_OK;
    end else if (wr_fire) begin
      bvalid_r <= 1'b1;
      bresp_r <= wr_hit ? `PCRS_RESP_OK : `PCRS_RESP_ERR;
    end else if (s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // read data select
  logic [7:0] rd_byte;
  always_comb begin
    unique case (s_axi_araddr)
      `PCRS_A_CLB: rd_byte = pc_r[7:0];
      `PCRS_A_HIL: rd_byte = hil_r;
      `PCRS_A_UPL: rd_byte = {3'h0, upl_r};
      `PCRS_A_SP: rd_byte = {full_r, unf_r, 1'b0, sp_r};
      `PCRS_A_TOP_LO: rd_byte = stack_top[7:0];
      `PCRS_A_TOP_HI: rd_byte = stack_top[15:8];
      `PCRS_A_TOP_UP: rd_byte = {3'h0, stack_top[20:16]};
      `PCRS_A_CFG: rd_byte = {7'h00, ore_r};
      default: rd_byte = 8'h00;
    endcase
  end
  wire [31:0] rd_word = (s_axi_araddr == `PCRS_A_PC) ? {11'h000, pc_r} : {24'h000000, rd_byte};

  // read response
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h00000000;
      rresp_r <= `PCRS_RESP_OK;
    end else if (rd_fire) begin
      rvalid_r <= 1'b1;
      rdata_r <= rd_hit ? rd_word : 32'h00000000;
      rresp_r <= rd_hit ? `PCRS_RESP_OK : `PCRS_RESP_ERR;
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // port drives
  assign s_axi_awready = ~aw_v_r;
  assign s_axi_wready = ~w_v_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = ~rvalid_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign instruction_pointer = pc_r;
  assign stack_full_flag = full_r;
  assign stack_underflow_flag = unf_r;
  assign stack_reset_req = req_r;

  // checks on the counter and stack
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  wire quiet = ~sys_reset & ~we_clb;
  // counter slices the latch checks look back on
  wire [7:0] pc_hi = pc_r[15:8];
  wire [4:0] pc_up = pc_r[20:16];
  sequence s_last_push;
    is_push & (sp_r == `PCRS_SP_LAST) & ~sys_reset;
  endsequence
  property p_adv;
    (seq_op == pcrs_pkg::PCRS_OP_ADV) & quiet |=> pc_r == $past(pc_r) + `PCRS_STEP;
  endproperty
  a_adv: assert property (p_adv) else $error("counter did not advance by two");
  property p_align;
    pc_r[0] == 1'b0;
  endproperty
  a_align: assert property (p_align) else $error("counter bit 0 set");
  property p_push;
    is_push & (sp_r < `PCRS_SP_LAST) & ~sys_reset |=> sp_r == $past(sp_inc) && stack_top == $past(pc_r);
  endproperty
  a_push: assert property (p_push) else $error("push did not store at new top");
  property p_ret;
    is_ret & ~sp_zero & ~sys_reset |=> pc_r == $past(stack_top) && sp_r == $past(sp_r) - 5'h01;
  endproperty
  a_ret: assert property (p_ret) else $error("return did not pop");
  property p_ovf;
    s_last_push ##0 ore_r |=> full_r && sp_r == 5'h00 && stack_reset_req && pc_r == 21'h000000;
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow reset missing");
  property p_sat;
    is_push & sp_top & ~ore_r & ~sys_reset |=> sp_top && full_r;
  endproperty
  a_sat: assert property (p_sat) else $error("pointer left 31 on extra push");
  property p_unf;
    is_ret & sp_zero |=> pc_r == 21'h000000 && unf_r && sp_zero;
  endproperty
  a_unf: assert property (p_unf) else $error("underflow not handled");
  property p_clb_wr;
    we_clb & (seq_op == pcrs_pkg::PCRS_OP_NONE) & ~sys_reset
      |=> pc_r[20:16] == $past(upl_r) && pc_r[15:8] == $past(hil_r);
  endproperty
  a_clb_wr: assert property (p_clb_wr) else $error("latches not loaded to counter");
  property p_clb_rd;
    rd_clb & ~dev_clr |=> hil_r == $past(pc_hi) && upl_r == $past(pc_up);
  endproperty
  a_clb_rd: assert property (p_clb_rd) else $error("counter not copied to latches");
  property p_call_latch;
    (is_push | is_ret) & ~rd_clb & ~we_hil & ~we_upl & ~dev_clr
      |=> $stable(hil_r) && $stable(upl_r);
  endproperty
  a_call_latch: assert property (p_call_latch) else $error("call changed latches");
endmodule
`default_nettype wire

// >>> pcrs_seq_model.sv
// sequencer model driving operations into the program counter block
`timescale 1ns/100ps
`default_nettype none
module pcrs_seq_model (
  input wire logic clk, // core clock
  output var pcrs_pkg::pcrs_op_t seq_op, // operation this cycle
  output var logic [20:0] seq_target // jump, call or vector target
);
  // idle between operations, target scrambled while unused
  initial begin
    seq_op = pcrs_pkg::PCRS_OP_NONE;
    seq_target = 21'h0AAAAA;
  end
  task automatic issue(input pcrs_pkg::pcrs_op_t op, input logic [20:0] t);
    @(posedge clk);
    seq_op <= op;
    seq_target <= t;
    @(posedge clk);
    seq_op <= pcrs_pkg::PCRS_OP_NONE;
    seq_target <= ~t;
  endtask
endmodule
`default_nettype wire

// >>> program_counter_return_stack_tb_top.sv
// self-checking testbench of the program counter and return stack
`timescale 1ns/100ps
`include "pcrs_defs.svh"
`default_nettype none
module program_counter_return_stack_tb_top;
  logic clk = 0, rst = 1, sys_reset = 0;
  pcrs_pkg::pcrs_op_t seq_op;
  logic [20:0] seq_target, ip, pc, t, p, e5;
  logic full, unf, sreq, awready, wready, bvalid, arready, rvalid;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [5:0] awaddr = 6'h00, araddr = 6'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] wstrb = 4'hF;
  logic [1:0] bresp, rresp;
  logic [33:0] expq[$];
  logic [1:0] bq[$];
  int n_mismatch = 0, cmp_count = 0, n_req = 0;
  localparam logic [1:0] OK = `PCRS_RESP_OK;
  localparam logic [1:0] ER = `PCRS_RESP_ERR;

  pcrs_seq_model sq (.clk(clk), .seq_op(seq_op), .seq_target(seq_target));
  pcrs_top uut (.clk(clk), .rst(rst), .sys_reset(sys_reset), .seq_op(seq_op),
    .seq_target(seq_target), .instruction_pointer(ip), .stack_full_flag(full),
    .stack_underflow_flag(unf), .stack_reset_req(sreq),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  // clock generation
  always #5 clk = ~clk;

  task automatic chk(input string nm, input logic [33:0] seen, input logic [33:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic close_out();
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // register write, response checked on arrival
  task automatic axw(input logic [5:0] a, input logic [31:0] d, input logic [1:0] r = OK);
    bq.push_back(r);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask

  // register read, expectation noted for the monitor
  task automatic axr(input logic [5:0] a, input logic [31:0] d, input logic [1:0] r = OK);
    expq.push_back({r, d});
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
  endtask

  // monitor takes the oldest note at each read response
  always @(posedge clk) begin
    if (rvalid === 1'b1 && rready === 1'b1) chk("rdata", {rresp, rdata}, expq.pop_front());
    if (bvalid === 1'b1 && bready === 1'b1) chk("bresp", {32'h0, bresp}, {32'h0, bq.pop_front()});
    if (sreq === 1'b1) n_req++;
  end

  function automatic logic [20:0] rnd();
    return 21'($urandom) & 21'h1FFFFE;
  endfunction

  task automatic pulse_sys();
    @(posedge clk);
    sys_reset <= 1'b1;
    @(posedge clk);
    sys_reset <= 1'b0;
  endtask

  // watchdog cuts a hang short
  initial begin
    #200us;
    n_mismatch++;
    close_out();
  end

  initial begin
    void'($urandom(28));
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    axr(`PCRS_A_SP, 32'h0);
    axr(`PCRS_A_CFG, 32'h1);
    axr(`PCRS_A_PC, 32'h0);
    repeat (3) sq.issue(pcrs_pkg::PCRS_OP_ADV, 21'h0);
    axr(`PCRS_A_PC, 32'h6);
    axw(`PCRS_A_HIL, 32'h12);
    axw(`PCRS_A_UPL, 32'hE5);
    axr(`PCRS_A_UPL, 32'h05);
    axw(`PCRS_A_CLB, 32'h35);
    axr(`PCRS_A_PC, 32'h051234);
    pc = rnd();
    sq.issue(pcrs_pkg::PCRS_OP_JUMP, pc);
    axr(`PCRS_A_PC, 32'(pc));
    chk("ip", 34'(ip), 34'(pc));
    p = pc;
    t = rnd();
    sq.issue(pcrs_pkg::PCRS_OP_CALL, t);
    axr(`PCRS_A_SP, 32'h1);
    axr(`PCRS_A_TOP_LO, 32'(p[7:0]));
    axr(`PCRS_A_TOP_HI, 32'(p[15:8]));
    axr(`PCRS_A_TOP_UP, 32'(p[20:16]));
    axr(`PCRS_A_HIL, 32'h12);
    axr(`PCRS_A_CLB, 32'(t[7:0]));
    axr(`PCRS_A_HIL, 32'(t[15:8]));
    axr(`PCRS_A_UPL, 32'(t[20:16]));
    sq.issue(pcrs_pkg::PCRS_OP_RET, 21'h0);
    axr(`PCRS_A_PC, 32'(p));
    chk("ip", 34'(ip), 34'(p));
    axr(`PCRS_A_SP, 32'h0);
    axr(`PCRS_A_HIL, 32'(t[15:8]));
    sq.issue(pcrs_pkg::PCRS_OP_PUSH, 21'h0);
    axr(`PCRS_A_TOP_HI, 32'(p[15:8]));
    sq.issue(pcrs_pkg::PCRS_OP_POP, 21'h0);
    axr(`PCRS_A_SP, 32'h0);
    axr(`PCRS_A_PC, 32'(p));
    // underflow with the reset on overflow disabled
    axw(`PCRS_A_CFG, 32'h0);
    sq.issue(pcrs_pkg::PCRS_OP_RET, 21'h0);
    axr(`PCRS_A_PC, 32'h0);
    axr(`PCRS_A_SP, 32'h40);
    chk("unf", {33'h0, unf}, 34'h1);
    axr(`PCRS_A_HIL, 32'(t[15:8]));
    chk("reset_req", 34'(n_req), 34'h0);
    pc = 21'h0;
    // fill the stack past its depth
    for (int i = 1; i <= 32; i++) begin
      if (i == 31) chk("full", {33'h0, full}, 34'h0);
      if (i == 5) e5 = pc;
      if (i == 31) p = pc;
      t = rnd();
      sq.issue(pcrs_pkg::PCRS_OP_CALL, t);
      pc = t;
    end
    axr(`PCRS_A_SP, 32'hDF);
    chk("full", {33'h0, full}, 34'h1);
    axr(`PCRS_A_TOP_LO, 32'(p[7:0]));
    pulse_sys();
    axr(`PCRS_A_SP, 32'hC0);
    axr(`PCRS_A_PC, 32'h0);
    axw(`PCRS_A_SP, 32'h05);
    axr(`PCRS_A_SP, 32'h05);
    axr(`PCRS_A_TOP_LO, 32'(e5[7:0]));
    axr(`PCRS_A_TOP_UP, 32'(e5[20:16]));
    // overflow and underflow with the reset enabled
    axw(`PCRS_A_CFG, 32'h1);
    axw(`PCRS_A_SP, 32'h1E);
    p = rnd();
    sq.issue(pcrs_pkg::PCRS_OP_JUMP, p);
    sq.issue(pcrs_pkg::PCRS_OP_CALL, rnd());
    axr(`PCRS_A_SP, 32'h80);
    axr(`PCRS_A_PC, 32'h0);
    chk("reset_req", 34'(n_req), 34'h1);
    axw(`PCRS_A_SP, 32'h9F);
    axr(`PCRS_A_TOP_HI, 32'(p[15:8]));
    axw(`PCRS_A_SP, 32'h0);
    sq.issue(pcrs_pkg::PCRS_OP_RET, 21'h0);
    axr(`PCRS_A_SP, 32'h40);
    chk("reset_req", 34'(n_req), 34'h2);
    // unmapped and misaligned places
    axr(6'h24, 32'h0, ER);
    axr(6'h22, 32'h0, ER);
    axw(6'h24, 32'hFF, ER);
    axr(`PCRS_A_SP, 32'h40);
    @(posedge clk);
    close_out();
  end
endmodule
`default_nettype wire
